/* File: rtl/fpc_pkg.sv */
// Constants and shared types for the four phase clock sequencer with single step.
// How it works
// - Four fixed-rotation phases, one oscillator half each.
// - Phase one sets low bit; two clears high.
// - Phase three: odd inhibit clear, high clear, half A.
// - During phase three clear low bit.
// - Phase four: even inhibit clear, low clear, half B.
// - During phase four set high bit.
// - Automatic mode rotates continuously without gaps.
// - Switches at rest leave recycling untouched.
// - Normal operation holds both inhibit flags clear.
// - Halt switch ignored while run flag set.
// - Clear removed only: halt, idle, no clear.
// - Stepping disables the memory timing chain.
// - Halt entry: helper set, even then odd inhibit.
// - Both inhibits set: no phase, oscillator runs.
// - Arming flag set while advance switch rests.
// - First advance clears even inhibit before phase two.
// - After stepped phase two: helper set, disarm.
// - Next half re-sets even inhibit, blocking a second phase two.
// - Next advance clears odd inhibit when helper set.
// - After phase three: disarm, helper clear, odd inhibit.
// - Phase one like three, four like two.
// - Symmetrical oscillator halves of equal length.
// - Master clear forces both inhibit flags clear.
package fpc_pkg;

  // System clock period and the printed oscillator timing, in nanoseconds.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int OSC_HALF_NS     = 400;
  localparam int CLOCK_CYCLE_NS  = 1600;
  // Cycles per oscillator half; the half is exact here, so rounding is moot.
  localparam int OSC_HALF_CYCLES = (OSC_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : OSC_HALF_NS / CLK_PERIOD_NS;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // Control register fields.
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_STEP_BIT = 1;

  // Status register fields.
  localparam int ST_PS_LOW_BIT   = 0;
  localparam int ST_PS_HIGH_BIT  = 1;
  localparam int ST_EVEN_INH_BIT = 2;
  localparam int ST_ODD_INH_BIT  = 3;
  localparam int ST_ARMED_BIT    = 4;
  localparam int ST_HELPER_BIT   = 5;
  localparam int ST_STEPMODE_BIT = 6;
  localparam int ST_HALF_B_BIT   = 7;
  localparam int ST_PHASE_LSB    = 8;

  // Reset values: ready to produce phase one on the first half A.
  localparam logic PS_LOW_RST  = 1'b0;
  localparam logic PS_HIGH_RST = 1'b1;

  // Phase enable encodings, one bit per phase.
  localparam logic [3:0] PHASE_NONE = 4'h0;
  localparam logic [3:0] PHASE_1    = 4'h1;
  localparam logic [3:0] PHASE_2    = 4'h2;
  localparam logic [3:0] PHASE_3    = 4'h4;
  localparam logic [3:0] PHASE_4    = 4'h8;

  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } fpc_bus_state_t;

endpackage : fpc_pkg

/* File: rtl/fpc_osc_if.sv */
// Interface between the oscillator and switch front end and the sequencer core.
`timescale 1ns/1ps
interface fpc_osc_if;
  logic haltRaw;       // Halt request before synchronisation.
  logic stepRaw;       // Advance switch, high while pressed, unsynchronised.
  logic oscHalfB;      // Low in the half serving phases one and three.
  logic halfEnd;       // One-cycle pulse in the last cycle of each half.
  logic haltLvl;       // Synchronised halt request.
  logic stepLvl;       // Synchronised advance switch level.
  logic stepReleased;  // One-cycle pulse when the advance switch returns to rest.

  modport osc  (input haltRaw, stepRaw, output oscHalfB, halfEnd, haltLvl, stepLvl, stepReleased);
  modport core (output haltRaw, stepRaw, input oscHalfB, halfEnd, haltLvl, stepLvl, stepReleased);
endinterface : fpc_osc_if

/* File: rtl/fpc_osc.sv */
// Base oscillator divider and operator switch synchronisers.
`timescale 1ns/1ps
module fpc_osc #(
  parameter int HALF_CYCLES = fpc_pkg::OSC_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  fpc_osc_if.osc   oscIf
);

  // A zero length half would freeze the rotation.
  if (HALF_CYCLES < 1) begin : g_bad_half
    $error("HALF_CYCLES must be at least one");
  end

  localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  // Whole state of the front end in one record.
  typedef struct packed {
    logic [CW-1:0] count;    // Cycles elapsed in the current half.
    logic          halfB;    // Current oscillator half.
    logic [1:0]    haltSync; // Two-stage synchroniser; bit 0 is the first stage.
    logic [1:0]    stepSync; // Two-stage synchroniser; bit 0 is the first stage.
    logic          stepPrev; // Previous synchronised advance level.
  } fpc_osc_state_t;

  fpc_osc_state_t st_q;
  fpc_osc_state_t st_d;

  // Both halves use the same count, which keeps the square wave symmetrical.
  always_comb begin
    st_d = st_q;
    if (st_q.count == LAST) begin
      st_d.count = '0;
      st_d.halfB = ~st_q.halfB;
    end else begin
      st_d.count = st_q.count + CW'(1);
    end
    // First stages feed only the second stages.
    st_d.haltSync = {st_q.haltSync[0], oscIf.haltRaw};
    st_d.stepSync = {st_q.stepSync[0], oscIf.stepRaw};
    st_d.stepPrev = st_q.stepSync[1];
  end

  // Reset starts the oscillator in half A with both switches seen at rest.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign oscIf.oscHalfB     = st_q.halfB;
  assign oscIf.halfEnd      = (st_q.count == LAST);
  assign oscIf.haltLvl      = st_q.haltSync[1];
  assign oscIf.stepLvl      = st_q.stepSync[1];
  assign oscIf.stepReleased = st_q.stepPrev & ~st_q.stepSync[1];

endmodule : fpc_osc

/* File: rtl/fpc_clock_seq.sv */
// Four phase master clock sequencer with halt and single phase stepping.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module fpc_clock_seq #(
  parameter int HALF_CYCLES = fpc_pkg::OSC_HALF_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Operator switches and machine state.
  input  wire logic        autoClockHaltSwitch,
  input  wire logic        phaseStepSwitch,
  input  wire logic        runFlag,
  input  wire logic        memoryChainBusy,
  input  wire logic        masterClearActive,
  // Clock phase enables to the logic chassis.
  output logic      [3:0]  phaseEnable,
  output logic      [1:0]  phaseState,
  output logic             memoryChainDisable,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  // A zero length half would freeze the rotation.
  if (HALF_CYCLES < 1) begin : g_bad_half
    $error("HALF_CYCLES must be at least one");
  end

  // Whole state of the sequencer in one record.
  typedef struct packed {
    logic                    psLow;      // Low phase-state bit.
    logic                    psHigh;     // High phase-state bit.
    logic                    evenInh;    // Blocks phases two and four.
    logic                    oddInh;     // Blocks phases one and three.
    logic                    armed;      // Step armed flag.
    logic                    helper;     // Step helper flag.
    logic [3:0]              phase;      // Registered phase enables.
    logic                    memDisable; // Registered memory chain disable.
    logic                    softHalt;   // Software halt request.
    logic                    softStep;   // Software advance request.
    fpc_pkg::fpc_bus_state_t bus;        // Bus slave state.
    logic                    waitReq;    // Registered waitrequest.
    logic [31:0]             rdata;      // Registered read data.
  } fpc_core_state_t;

  fpc_core_state_t st_q;
  fpc_core_state_t st_d;

  // Front end: oscillator and switch synchronisers.
  fpc_osc_if oscIf ();

  // Software may stand in for the console switches; either source acts.
  assign oscIf.haltRaw = autoClockHaltSwitch | st_q.softHalt;
  assign oscIf.stepRaw = phaseStepSwitch | st_q.softStep;

  fpc_osc #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_osc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .oscIf    (oscIf)
  );

  // Stepping mode is entered only when halt is asked, the machine is not
  // running, memory is idle and no master clear is in progress. Waiting for
  // memory to go idle keeps a reference from being cut in half.
  logic stepMode;
  assign stepMode = oscIf.haltLvl
                  & ~runFlag
                  & ~memoryChainBusy
                  & ~masterClearActive;

  // Half A serves phases one and three, half B phases two and four.
  logic halfA;
  logic halfB;
  assign halfB = oscIf.oscHalfB;
  assign halfA = ~oscIf.oscHalfB;

  // An advance is a pressed switch while the arming flag is still set.
  logic advance;
  assign advance = oscIf.stepLvl & st_q.armed;

  // Phase decode from the flags and the oscillator half. Each half can yield
  // at most one phase, so the four enables are exclusive by construction.
  function automatic logic [3:0] decodePhase(
    input logic hb,
    input logic low,
    input logic high,
    input logic evenI,
    input logic oddI
  );
    logic [3:0] p;
    p = fpc_pkg::PHASE_NONE;
    if (!hb) begin
      if (!oddI && high) begin
        p = fpc_pkg::PHASE_1;
      end else if (!oddI && !high) begin
        p = fpc_pkg::PHASE_3;
      end
    end else begin
      if (!evenI && low) begin
        p = fpc_pkg::PHASE_2;
      end else if (!evenI && !low) begin
        p = fpc_pkg::PHASE_4;
      end
    end
    return p;
  endfunction : decodePhase

  // Phase currently being driven, seen from the flags as they stand.
  logic [3:0] phaseNow;
  assign phaseNow = decodePhase(halfB, st_q.psLow, st_q.psHigh, st_q.evenInh, st_q.oddInh);

  // Bus decode helpers.
  logic busReq;
  assign busReq = avs_read | avs_write;

  // Next-state logic for the sequencer, the step flags and the bus slave.
  always_comb begin
    st_d = st_q;

    // Phase-state bits advance at the end of the half in which a phase ran,
    // so the next half sees its selection with no dead half between them.
    if (oscIf.halfEnd) begin
      if (halfA && !st_q.oddInh) begin
        if (st_q.psHigh) begin
          st_d.psLow = 1'b1;
        end else begin
          st_d.psLow = 1'b0;
        end
      end
      if (halfB && !st_q.evenInh) begin
        if (st_q.psLow) begin
          st_d.psHigh = 1'b0;
        end else begin
          st_d.psHigh = 1'b1;
        end
      end
    end

    // Step flag network, evaluated once per oscillator half.
    if (oscIf.halfEnd) begin
      if (halfB && !st_q.evenInh) begin
        // A phase two or four just ran: remember it and disarm.
        st_d.helper = 1'b1;
        st_d.armed  = 1'b0;
      end
      if (halfA && !st_q.oddInh) begin
        // A phase one or three just ran.
        st_d.helper = 1'b0;
        st_d.armed  = 1'b0;
      end
      if (halfA && st_q.helper) begin
        st_d.evenInh = 1'b1;
      end
      if (halfB && !st_q.helper) begin
        st_d.oddInh = 1'b1;
      end
      if (halfA && advance && !st_q.helper && st_q.oddInh) begin
        st_d.evenInh = 1'b0;
      end
      if (halfB && advance && st_q.helper && st_q.evenInh) begin
        st_d.oddInh = 1'b0;
      end
    end

    // A switch at rest re-arms at once; the release pulse also re-arms, though it only comes with the
    // switch at rest, and a press that misses the last cycle of a half is lost. Re-arming wins
    // over a same-cycle disarm because the switch is no longer pressed.
    if (!oscIf.stepLvl || oscIf.stepReleased) begin
      st_d.armed = 1'b1;
    end

    // Outside stepping mode the inhibits are cleared at every half boundary,
    // which keeps the rotation free running whatever the advance switch does.
    // Clearing on the boundary rather than at once costs up to one half of
    // delay on leaving a halt, but never lets a clipped phase reach the chassis.
    if (!stepMode && oscIf.halfEnd) begin
      st_d.evenInh = 1'b0;
      st_d.oddInh  = 1'b0;
    end

    // With both inhibits set the decode yields nothing while the oscillator
    // keeps running, so the outputs simply fall silent.
    st_d.phase = decodePhase(halfB, st_q.psLow, st_q.psHigh, st_q.evenInh, st_q.oddInh);

    // Memory references are blocked for as long as stepping is possible.
    st_d.memDisable = stepMode;

    // Avalon slave: one wait cycle, then one cycle with waitrequest low.
    case (st_q.bus)
      fpc_pkg::BUS_IDLE: begin
        st_d.waitReq = 1'b1;
        if (busReq) begin
          st_d.bus     = fpc_pkg::BUS_ACK;
          st_d.waitReq = 1'b0;
          st_d.rdata   = '0;
          if (avs_read) begin
            if (avs_address == fpc_pkg::CTRL_OFS) begin
              st_d.rdata[fpc_pkg::CTRL_HALT_BIT] = st_q.softHalt;
              st_d.rdata[fpc_pkg::CTRL_STEP_BIT] = st_q.softStep;
            end else if (avs_address == fpc_pkg::STATUS_OFS) begin
              st_d.rdata[fpc_pkg::ST_PS_LOW_BIT]   = st_q.psLow;
              st_d.rdata[fpc_pkg::ST_PS_HIGH_BIT]  = st_q.psHigh;
              st_d.rdata[fpc_pkg::ST_EVEN_INH_BIT] = st_q.evenInh;
              st_d.rdata[fpc_pkg::ST_ODD_INH_BIT]  = st_q.oddInh;
              st_d.rdata[fpc_pkg::ST_ARMED_BIT]    = st_q.armed;
              st_d.rdata[fpc_pkg::ST_HELPER_BIT]   = st_q.helper;
              st_d.rdata[fpc_pkg::ST_STEPMODE_BIT] = stepMode;
              st_d.rdata[fpc_pkg::ST_HALF_B_BIT]   = halfB;
              st_d.rdata[fpc_pkg::ST_PHASE_LSB +: 4] = phaseNow;
            end else begin
              // Unmapped addresses read as zero.
              st_d.rdata = '0;
            end
          end
        end
      end
      fpc_pkg::BUS_ACK: begin
        // The master samples waitrequest low at this edge and releases.
        st_d.bus     = fpc_pkg::BUS_IDLE;
        st_d.waitReq = 1'b1;
        if (avs_write && avs_address == fpc_pkg::CTRL_OFS) begin
          st_d.softHalt = avs_writedata[fpc_pkg::CTRL_HALT_BIT];
          st_d.softStep = avs_writedata[fpc_pkg::CTRL_STEP_BIT];
        end
      end
      default: begin
        // Recover from an illegal code by returning to idle.
        st_d.bus     = fpc_pkg::BUS_IDLE;
        st_d.waitReq = 1'b1;
      end
    endcase
  end

  // Reset leaves the clock free running, ready for phase one, bus idle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q            <= '0;
      st_q.psLow      <= fpc_pkg::PS_LOW_RST;
      st_q.psHigh     <= fpc_pkg::PS_HIGH_RST;
      st_q.armed      <= 1'b1;
      st_q.bus        <= fpc_pkg::BUS_IDLE;
      st_q.waitReq    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Every output comes straight from the state record.
  assign phaseEnable        = st_q.phase;
  assign phaseState         = {st_q.psHigh, st_q.psLow};
  assign memoryChainDisable = st_q.memDisable;
  assign avs_readdata       = st_q.rdata;
  assign avs_waitrequest    = st_q.waitReq;

endmodule : fpc_clock_seq

/* File: tb/fpc_clock_seq_monitor.sv */
// Checker that watches the phase enables of the clock sequencer at its ports.
`timescale 1ns/1ps
module fpc_clock_seq_mon #(
  parameter int HC = 4
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       runFlag,
  input wire logic       memoryChainBusy,
  input wire logic       masterClearActive,
  input wire logic [3:0] phaseEnable,
  input wire logic       memoryChainDisable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] prevPe_q;  // Enable seen at the previous edge.
  int         runLen_q;  // Length of the run that prevPe_q belongs to.
  // A counter measures each half, because a repetition cannot take a parameter.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevPe_q <= 4'h0;
      runLen_q <= 0;
    end else begin
      prevPe_q <= phaseEnable;
      runLen_q <= (phaseEnable != prevPe_q) ? 1 : runLen_q + 1;
    end
  end
  AST_EXCLUSIVE: assert property ($onehot0(phaseEnable))
    else $error("two phases enabled at once");
  AST_HALF_LEN: assert property ((phaseEnable != prevPe_q) && (prevPe_q != 4'h0) |-> runLen_q == HC)
    else $error("phase did not last one oscillator half");
  AST_AFTER_ONE: assert property ($past(phaseEnable) == 4'h1 && phaseEnable != 4'h1 |-> phaseEnable inside {4'h0, 4'h2})
    else $error("phase one not followed by phase two");
  AST_AFTER_TWO: assert property (prevPe_q == 4'h2 && phaseEnable != 4'h2 |-> phaseEnable inside {4'h0, 4'h4})
    else $error("phase two not followed by phase three");
  AST_AFTER_THREE: assert property (prevPe_q == 4'h4 && phaseEnable != 4'h4 |-> phaseEnable inside {4'h0, 4'h8})
    else $error("phase three not followed by phase four");
  AST_AFTER_FOUR: assert property (prevPe_q == 4'h8 && phaseEnable != 4'h8 |-> phaseEnable inside {4'h0, 4'h1})
    else $error("phase four not followed by phase one");
  AST_RUN_KEEPS_CLOCK: assert property (runFlag [*8] |-> phaseEnable != 4'h0)
    else $error("clock silent while running");
  AST_CLEAR_RESTORES: assert property (masterClearActive [*8] |-> phaseEnable != 4'h0)
    else $error("clock silent during master clear");
  AST_BUSY_KEEPS_CLOCK: assert property (memoryChainBusy [*8] |-> phaseEnable != 4'h0)
    else $error("clock silent while memory busy");
  AST_NO_DISABLE: assert property (runFlag || memoryChainBusy || masterClearActive |=> !memoryChainDisable)
    else $error("memory chain disabled while halt refused");
  // Main scenarios: halt entry, a stepped phase two, a full wrap of the rotation.
  cover property ($rose(memoryChainDisable));
  cover property (memoryChainDisable && phaseEnable == 4'h2);
  cover property (prevPe_q == 4'h8 && phaseEnable == 4'h1);
endmodule : fpc_clock_seq_mon
bind fpc_clock_seq fpc_clock_seq_mon #(.HC(HALF_CYCLES)) u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .runFlag(runFlag), .memoryChainBusy(memoryChainBusy), .masterClearActive(masterClearActive),
  .phaseEnable(phaseEnable), .memoryChainDisable(memoryChainDisable));

/* File: tb/fpc_console_model.sv */
// Model of the operator switches and the chassis clock buses around the sequencer.
`timescale 1ns/1ps
module fpc_console_model (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [3:0] phaseEnable,
  output logic           autoClockHaltSwitch,
  output logic           phaseStepSwitch
);
  int         phaseCount;  // Phase starts seen on the chassis buses.
  logic [3:0] lastPhase;   // Most recent phase to start.
  logic [3:0] prevPe;      // Enable at the previous edge.
  // Both switches rest in their normal positions from time zero.
  initial begin
    autoClockHaltSwitch = 1'b0;
    phaseStepSwitch     = 1'b0;
  end
  // The chassis acts on each new enable, so starts are counted, not cycles.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseCount <= 0;
      lastPhase  <= 4'h0;
      prevPe     <= 4'h0;
    end else begin
      prevPe <= phaseEnable;
      if (phaseEnable != 4'h0 && phaseEnable != prevPe) begin
        phaseCount <= phaseCount + 1;
        lastPhase  <= phaseEnable;
      end
    end
  end
  // Operator moves the switches just after an edge; a step press ends by returning to rest.
  task automatic set_sw(input logic halt, input logic step);
    @(posedge core_clk);
    autoClockHaltSwitch <= halt;
    phaseStepSwitch     <= step;
  endtask : set_sw
endmodule : fpc_console_model

/* File: tb/tb.sv */
// Self-checking bench for the four phase clock sequencer.
`timescale 1ns/1ps
module tb;
  localparam int HC = 2;  // Short halves keep the run brief.
  logic        core_clk;
  logic        sys_rst;
  logic        autoClockHaltSwitch;
  logic        phaseStepSwitch;
  logic        runFlag;
  logic        memoryChainBusy;
  logic        masterClearActive;
  logic [3:0]  phaseEnable;
  logic [1:0]  phaseState;
  logic        memoryChainDisable;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          bad_count;
  int          check_count;
  int          cycles;
  int          c;
  logic [31:0] rd;
  fpc_clock_seq #(.HALF_CYCLES(HC)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .autoClockHaltSwitch(autoClockHaltSwitch), .phaseStepSwitch(phaseStepSwitch), .runFlag(runFlag),
    .memoryChainBusy(memoryChainBusy), .masterClearActive(masterClearActive), .phaseEnable(phaseEnable),
    .phaseState(phaseState), .memoryChainDisable(memoryChainDisable), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  fpc_console_model u_con (.core_clk(core_clk), .sys_rst(sys_rst), .phaseEnable(phaseEnable),
    .autoClockHaltSwitch(autoClockHaltSwitch), .phaseStepSwitch(phaseStepSwitch));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // The whole run needs well under a thousand cycles; a hang is cut off here.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  // One bus cycle; the request rises just after an edge and stands until waitrequest is seen low.
  // The leading edge keeps a second call from raising read in the step that released it.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_n
  // Waits until the chassis model has seen the next phase start.
  task automatic wait_start();
    c = u_con.phaseCount;
    while (u_con.phaseCount == c) @(posedge core_clk);
  endtask : wait_start
  // Free rotation from reset: 1, 2, 3, 4 and back to 1.
  task automatic t_free();
    for (int i = 0; i < 5; i++) begin
      wait_start();
      chk(u_con.lastPhase, 4'h1 << (i % 4), "rotation order");
    end
  endtask : t_free
  // Status register in free run, and an unmapped address.
  task automatic t_regs();
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b0, 4'h4, 32'h0);
    chk(rd & 32'h5c, 32'h10, "free run status");
  endtask : t_regs
  // Halt: the clock falls silent and memory is locked out. The switch is thrown so that
  // it is seen early in a phase one half, after phase four; the model reports a start one
  // cycle late and the switch passes two synchroniser stages, hence the short wait.
  task automatic t_halt();
    do wait_start(); while (u_con.lastPhase != 4'h1);
    wait_n(2);
    u_con.set_sw(1'b1, 1'b0);
    wait_n(30);
    c = u_con.phaseCount;
    wait_n(20);
    chk(u_con.phaseCount, c, "phase while halted");
    chk(memoryChainDisable, 1'b1, "memory not disabled");
    chk(phaseState, 2'h3, "phase state at halt");
    bus(1'b0, 4'h4, 32'h0);
    chk(rd & 32'h7c, 32'h5c, "halt entry flags");
  endtask : t_halt
  // Four long presses: exactly one phase each, in the order 2, 3, 4, 1.
  task automatic t_step();
    for (int i = 0; i < 4; i++) begin
      c = u_con.phaseCount;
      u_con.set_sw(1'b1, 1'b1);
      wait_n(20);
      chk(u_con.phaseCount, c + 1, "phases per press");
      chk(u_con.lastPhase, (i == 3) ? 4'h1 : 4'h2 << i, "stepped phase");
      bus(1'b0, 4'h4, 32'h0);
      chk(rd & 32'h7c, (i % 2 == 0) ? 32'h6c : 32'h4c, "flags after step");
      u_con.set_sw(1'b1, 1'b0);
      wait_n(10);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd[4], 1'b1, "not rearmed at rest");
    end
  endtask : t_step
  // Run, master clear and memory use each refuse the halt while they last.
  task automatic t_override();
    for (int i = 0; i < 3; i++) begin
      {memoryChainBusy, masterClearActive, runFlag} <= 3'h1 << i;
      c = u_con.phaseCount;
      wait_n(20);
      chk(u_con.phaseCount > c, 1'b1, "clock held by halt");
      chk(memoryChainDisable, 1'b0, "memory disabled");
      {memoryChainBusy, masterClearActive, runFlag} <= 3'h0;
      wait_n(30);
    end
  endtask : t_override
  // Switches back to rest, then software halt through the control register.
  task automatic t_release();
    u_con.set_sw(1'b0, 1'b0);
    wait_n(30);
    bus(1'b1, 4'h0, 32'h1);
    wait_n(30);
    chk(memoryChainDisable, 1'b1, "software halt ignored");
    // A software advance held high gives one phase only.
    c = u_con.phaseCount;
    bus(1'b1, 4'h0, 32'h3);
    wait_n(20);
    chk(u_con.phaseCount, c + 1, "software advance");
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h3, "control readback");
    bus(1'b1, 4'h0, 32'h0);
    wait_n(30);
    c = u_con.phaseCount;
    wait_n(32);
    chk(u_con.phaseCount, c + 16, "gaps in free run");
    bus(1'b0, 4'h4, 32'h0);
    chk(rd & 32'h4c, 32'h0, "inhibits not cleared");
  endtask : t_release
  initial begin
    sys_rst           = 1'b1;
    runFlag           = 1'b0;
    memoryChainBusy   = 1'b0;
    masterClearActive = 1'b0;
    avs_address       = 4'h0;
    avs_read          = 1'b0;
    avs_write         = 1'b0;
    avs_writedata     = 32'h0;
    bad_count         = 0;
    check_count       = 0;
    cycles            = 0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_free();
    t_regs();
    t_halt();
    t_step();
    u_con.set_sw(1'b1, 1'b0);
    t_override();
    t_release();
    test_done();
  end
endmodule : tb
